/* core/asc_ctrl.sv */
// asc_ctrl: host controller driving an asynchronous 128K x 16 static memory
// ==========================
// Behaviour
// RL1: the memory holds 131072 words of 16 bits in two separately reachable byte lanes.
// RL2: the memory writes only while select, write strobe and a lane select are all low.
// RL3: a write ends on the first select to rise; data is held across that edge.
// RL4: with output gate high the memory leaves the data lines undriven.
// RL5: select rising while write strobe is high leaves the data lines undriven.
// RL6: the controller never drives the data lines while the memory may drive them.
// RL7: the controller always holds select and lane selects at a firm level.
// RL8: a read with both lanes low returns the whole word on lines 0 to 15.
// RL9: a read with only the lower lane returns lines 0 to 7.
// RL10: a read with only the upper lane returns lines 8 to 15.
// RL11: a write with both lanes low stores both bytes driven by the controller.
// RL12: a lower-lane write stores lines 0 to 7 and leaves the upper byte alone.
// RL13: an upper-lane write stores lines 8 to 15 and leaves the lower byte alone.
// RL14: select high or both lanes high deselects the memory.
// RL15: the controller holds the lane selects steady while the chip is disabled.
// RL16: select low, strobe high and gate high gives no write and no drive.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl (
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [asc_pkg::ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [asc_pkg::DATA_W-1:0] REQ_WDATA_IN,
  input wire logic [1:0] REQ_LANE_IN,
  input wire logic [asc_pkg::DATA_W-1:0] MEM_DQ_IN,
  output logic REQ_READY_OUT,
  output logic RSP_VALID_OUT,
  output logic [asc_pkg::DATA_W-1:0] RSP_RDATA_OUT,
  output logic MEM_CS_N_OUT,
  output logic MEM_WE_N_OUT,
  output logic MEM_OE_N_OUT,
  output logic MEM_UPPER_LANE_SELECT_N_OUT,
  output logic MEM_LOWER_LANE_SELECT_N_OUT,
  output logic [asc_pkg::ADDR_W-1:0] MEM_ADDR_OUT,
  output logic [asc_pkg::DATA_W-1:0] MEM_DQ_OUT,
  output logic [asc_pkg::DATA_W-1:0] MEM_DQ_OE_OUT
);
  import asc_pkg::*;

  asc_pin_if pins ();

  // ==========================
  // pin input synchroniser
  // the memory's lines change with no relation to our clock
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= MEM_DQ_IN;
      dq_s2_r <= dq_s1_r;
    end
  end

  // lanes requested, low active on the pins; none means whole word
  // a code with both bits set also asks for the whole word
  function automatic logic [1:0] lanes_of(input logic [1:0] req);
    lanes_of = (req == LANES_NONE) ? 2'h3 : req;
  endfunction

  // ==========================
  // sequencer state
  asc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [1:0] lane_r, lane_nxt;
  logic rsp_r, rsp_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;

  // ==========================
  // per-lane read masking
  // lanes not asked for read as zero, whatever the released lines show
  logic [DATA_W-1:0] rd_masked;
  for (genvar gl = 0; gl < 2; gl++) begin : g_lane
    assign rd_masked[gl*BYTE_W +: BYTE_W] = lane_r[gl] ? dq_s2_r[gl*BYTE_W +: BYTE_W] : '0;
  end

  // next-state logic
  // one request at a time; ready drops while a transfer runs
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    lane_nxt = lane_r; // RL15 lanes held unless a request is taken
    rsp_nxt = 1'b0;
    rdata_nxt = rdata_r;
    ready_nxt = 1'b0;
    case (state_r)
      ASC_IDLE: begin
        ready_nxt = 1'b1;
        // take a request only on an edge that already shows ready
        if (REQ_VALID_IN && ready_r) begin
          ready_nxt = 1'b0;
          addr_nxt = REQ_ADDR_IN;
          wdata_nxt = REQ_WDATA_IN;
          lane_nxt = lanes_of(REQ_LANE_IN);
          if (REQ_WRITE_IN) begin
            state_nxt = ASC_WRSET;
            cnt_nxt = CNT_W'(SD_CYC);
          end else begin
            state_nxt = ASC_RD;
            cnt_nxt = CNT_W'(RD_CYC + 2);
          end
        end
      end
      ASC_RD: begin
        if (cnt_r == CNT_ZERO) begin
          // sample once the synchronised lines have settled
          rdata_nxt = rd_masked; // RL8 RL9 RL10
          rsp_nxt = 1'b1;
          state_nxt = ASC_RDEND;
          cnt_nxt = CNT_W'(HZ_CYC);
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ASC_RDEND: begin
        // wait for the memory to release the lines before any write
        if (cnt_r == CNT_ZERO) begin
          state_nxt = ASC_IDLE;
          ready_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ASC_WRSET: begin
        // data and selects settle one cycle before the strobe falls
        state_nxt = ASC_WR;
        cnt_nxt = CNT_W'(WR_CYC);
      end
      ASC_WR: begin
        // strobe stays low for the write count plus one cycle
        if (cnt_r == CNT_ZERO) begin
          state_nxt = ASC_TURN; // RL3 strobe rises, data still held
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ASC_TURN: begin
        // strobe is high again; select and data held one more cycle
        state_nxt = ASC_IDLE;
        ready_nxt = 1'b1;
      end
      default: begin
        // an illegal code falls back to idle
        state_nxt = ASC_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r <= ASC_IDLE;
      cnt_r <= CNT_ZERO;
      addr_r <= '0;
      wdata_r <= '0;
      lane_r <= LANES_NONE;
      rsp_r <= 1'b0;
      rdata_r <= '0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      lane_r <= lane_nxt;
      rsp_r <= rsp_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ==========================
  // pin decode, registered in the pin driver
  // decoding the next state lets the pin registers switch on the same
  // edge as the sequencer, so the pins do not trail it by a cycle
  // the data lines are driven only in write states, so a read and a
  // drive never overlap on the pins
  logic in_rd, in_wr, in_wrdrv;
  assign in_rd = (state_nxt == ASC_RD);
  assign in_wr = (state_nxt == ASC_WR);
  assign in_wrdrv = (state_nxt == ASC_WRSET) || in_wr || (state_nxt == ASC_TURN);
  assign pins.cs_n = ~(in_rd || in_wrdrv); // RL14 deselect when idle
  assign pins.we_n = ~in_wr; // RL2 RL11
  assign pins.oe_n = ~in_rd; // RL4 RL16 gate high during writes
  assign pins.lane_n = ~lane_nxt; // RL12 RL13
  assign pins.addr = addr_nxt;
  assign pins.wdata = wdata_nxt;
  // drive only the written lanes, never while reading
  assign pins.drive = in_wrdrv ? lane_nxt : LANES_NONE; // RL6 RL5 RL12 RL13

  // every memory pin leaves through a register
  asc_pin_drv u_pin_drv (
    .clk(CORE_CLK_IN),
    .rst_b(RST_B_IN),
    .pins(pins),
    .cs_n_q(MEM_CS_N_OUT),
    .we_n_q(MEM_WE_N_OUT),
    .oe_n_q(MEM_OE_N_OUT),
    .upper_lane_select_n_q(MEM_UPPER_LANE_SELECT_N_OUT),
    .lower_lane_select_n_q(MEM_LOWER_LANE_SELECT_N_OUT),
    .addr_q(MEM_ADDR_OUT),
    .dq_o_q(MEM_DQ_OUT),
    .dq_oe_q(MEM_DQ_OE_OUT)
  );

  // ==========================
  // response outputs
  // read data holds until the next read answer
  assign REQ_READY_OUT = ready_r;
  assign RSP_VALID_OUT = rsp_r;
  assign RSP_RDATA_OUT = rdata_r;
endmodule
`default_nettype wire

/* core/asc_pin_drv.sv */
// asc_pin_drv: registers every memory pin and the data drive enables
`timescale 1ns/1ps
`default_nettype none
module asc_pin_drv (
  input wire logic clk,
  input wire logic rst_b,
  asc_pin_if.dst pins,
  output logic cs_n_q,
  output logic we_n_q,
  output logic oe_n_q,
  output logic upper_lane_select_n_q,
  output logic lower_lane_select_n_q,
  output logic [asc_pkg::ADDR_W-1:0] addr_q,
  output logic [asc_pkg::DATA_W-1:0] dq_o_q,
  output logic [asc_pkg::DATA_W-1:0] dq_oe_q
);
  import asc_pkg::*;
  // ==========================
  // pin register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_n_q <= 1'b1; // RL7
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      upper_lane_select_n_q <= 1'b1; // RL7
      lower_lane_select_n_q <= 1'b1;
      addr_q <= '0;
      dq_o_q <= '0;
      dq_oe_q <= '0;
    end else begin
      cs_n_q <= pins.cs_n;
      we_n_q <= pins.we_n;
      oe_n_q <= pins.oe_n;
      upper_lane_select_n_q <= pins.lane_n[1];
      lower_lane_select_n_q <= pins.lane_n[0];
      addr_q <= pins.addr;
      dq_o_q <= pins.wdata;
      // per-lane drive enables
      dq_oe_q <= {{BYTE_W{pins.drive[1]}}, {BYTE_W{pins.drive[0]}}}; // RL6
    end
  end
endmodule
`default_nettype wire

/* core/asc_pin_if.sv */
// asc_pin_if: pin signals between sequencer and pin driver
`timescale 1ns/1ps
`default_nettype none
interface asc_pin_if;
  import asc_pkg::*;
  logic cs_n;
  logic we_n;
  logic oe_n;
  logic [1:0] lane_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [1:0] drive;
  modport src (output cs_n, we_n, oe_n, lane_n, addr, wdata, drive);
  modport dst (input cs_n, we_n, oe_n, lane_n, addr, wdata, drive);
endinterface
`default_nettype wire

/* core/asc_pkg.sv */
// asc_pkg: constants and types for the static memory controller
package asc_pkg;
  // ==========================
  // geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int unsigned WORDS = 131072;
  // ==========================
  // timing at 40 MHz (25 ns period)
  localparam int CLK_PS = 25000;
  localparam int T_RC_PS = 45000;
  localparam int T_PWE_PS = 35000;
  localparam int T_SD_PS = 25000;
  localparam int T_HZ_PS = 18000;
  // least times round up
  localparam int RD_CYC = (T_RC_PS + CLK_PS - 1) / CLK_PS;
  localparam int WR_CYC = (T_PWE_PS + CLK_PS - 1) / CLK_PS;
  localparam int SD_CYC = (T_SD_PS + CLK_PS - 1) / CLK_PS;
  localparam int HZ_CYC = (T_HZ_PS + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [1:0] LANES_NONE = 2'h0;
  // ==========================
  // sequencer states
  typedef enum logic [5:0] {
    ASC_IDLE  = 6'h01,
    ASC_RD    = 6'h02,
    ASC_RDEND = 6'h04,
    ASC_WRSET = 6'h08,
    ASC_WR    = 6'h10,
    ASC_TURN  = 6'h20
  } asc_state_t;
endpackage

/* tb/asc_ctrl_chk.sv */
// asc_ctrl_chk: pin protocol assertions for the memory controller
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_chk (
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic RSP_VALID_OUT,
  input wire logic MEM_CS_N_OUT,
  input wire logic MEM_WE_N_OUT,
  input wire logic MEM_OE_N_OUT,
  input wire logic MEM_UPPER_LANE_SELECT_N_OUT,
  input wire logic MEM_LOWER_LANE_SELECT_N_OUT,
  input wire logic [asc_pkg::DATA_W-1:0] MEM_DQ_OUT,
  input wire logic [asc_pkg::DATA_W-1:0] MEM_DQ_OE_OUT
);
  import asc_pkg::*;
  logic up, lo;
  assign up = MEM_UPPER_LANE_SELECT_N_OUT;
  assign lo = MEM_LOWER_LANE_SELECT_N_OUT;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // ==========================
  // write and read pin sequencing
  a_write_qualified: assert property (!MEM_WE_N_OUT |-> !MEM_CS_N_OUT && !(up && lo))
    else $error("strobe low without selects");
  a_strobe_width: assert property ($fell(MEM_WE_N_OUT) |-> !MEM_WE_N_OUT[*3] ##1 MEM_WE_N_OUT)
    else $error("strobe width wrong");
  a_data_hold: assert property ($rose(MEM_WE_N_OUT) |-> $stable(MEM_DQ_OUT) && !MEM_CS_N_OUT)
    else $error("data not held at write end");
  a_gate_no_drive: assert property (!MEM_OE_N_OUT |-> MEM_DQ_OE_OUT == 16'h0000)
    else $error("drive while gate low");
  a_gate_off_write: assert property (!MEM_WE_N_OUT |-> MEM_OE_N_OUT)
    else $error("gate low in write");
  a_upper_drive: assert property (|MEM_DQ_OE_OUT[15:8] |-> !up && !MEM_CS_N_OUT)
    else $error("upper lines driven unselected");
  a_lower_drive: assert property (|MEM_DQ_OE_OUT[7:0] |-> !lo && !MEM_CS_N_OUT)
    else $error("lower lines driven unselected");
  a_lanes_steady: assert property (MEM_CS_N_OUT && $past(MEM_CS_N_OUT) |-> $stable({up, lo}))
    else $error("lane selects moved while disabled");
  a_read_answer: assert property ($fell(MEM_OE_N_OUT) |-> ##5 RSP_VALID_OUT)
    else $error("read answer late");
  c_low_write: cover property ($fell(MEM_WE_N_OUT) && up && !lo);
  c_up_write: cover property ($fell(MEM_WE_N_OUT) && !up && lo);
  c_read: cover property (RSP_VALID_OUT);
endmodule
bind asc_ctrl asc_ctrl_chk u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
  .RSP_VALID_OUT(RSP_VALID_OUT), .MEM_CS_N_OUT(MEM_CS_N_OUT), .MEM_WE_N_OUT(MEM_WE_N_OUT),
  .MEM_OE_N_OUT(MEM_OE_N_OUT), .MEM_UPPER_LANE_SELECT_N_OUT(MEM_UPPER_LANE_SELECT_N_OUT),
  .MEM_LOWER_LANE_SELECT_N_OUT(MEM_LOWER_LANE_SELECT_N_OUT), .MEM_DQ_OUT(MEM_DQ_OUT),
  .MEM_DQ_OE_OUT(MEM_DQ_OE_OUT));
`default_nettype wire

/* tb/asc_ctrl_tb_top.sv */
// asc_ctrl_tb_top: directed tests of the controller against the memory model
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_tb_top;
  import asc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, valid = 1'b0, write = 1'b0;
  logic [ADDR_W-1:0] addr = 17'h00000, maddr;
  logic [DATA_W-1:0] wdata = 16'h0000, line, rdata, dq, dq_oe, q;
  logic [1:0] lane = 2'h0;
  logic ready, rsp, cs_n, we_n, oe_n, up_n, lo_n;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  always #12.5 clk = ~clk;
  asc_ctrl dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .REQ_VALID_IN(valid), .REQ_WRITE_IN(write),
    .REQ_ADDR_IN(addr), .REQ_WDATA_IN(wdata), .REQ_LANE_IN(lane), .MEM_DQ_IN(line),
    .REQ_READY_OUT(ready), .RSP_VALID_OUT(rsp), .RSP_RDATA_OUT(rdata), .MEM_CS_N_OUT(cs_n),
    .MEM_WE_N_OUT(we_n), .MEM_OE_N_OUT(oe_n), .MEM_UPPER_LANE_SELECT_N_OUT(up_n),
    .MEM_LOWER_LANE_SELECT_N_OUT(lo_n), .MEM_ADDR_OUT(maddr), .MEM_DQ_OUT(dq),
    .MEM_DQ_OE_OUT(dq_oe));
  asc_mem_model u_mem (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .up_n(up_n), .lo_n(lo_n),
    .addr(maddr), .din(dq), .din_oe(dq_oe), .line(line));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one request, held until the edge that sees ready
  task automatic req(input logic w, input logic [16:0] a, input logic [15:0] d,
      input logic [1:0] l);
    @(negedge clk);
    valid = 1'b1;
    write = w;
    addr = a;
    wdata = d;
    lane = l;
    while (ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
  endtask
  task automatic rd(input logic [16:0] a, input logic [1:0] l);
    req(1'b0, a, 16'h0000, l);
    while (rsp !== 1'b1) @(negedge clk);
    q = rdata;
  endtask
  // whole words at both ends of the array
  task automatic t_word();
    req(1'b1, 17'h00000, 16'h1234, 2'h0);
    req(1'b1, 17'h1FFFF, 16'hBEEF, 2'h0);
    rd(17'h00000, 2'h0);
    chk("word low end", q, 16'h1234);
    rd(17'h1FFFF, 2'h3);
    chk("word high end", q, 16'hBEEF);
  endtask
  // single lane writes keep the other byte
  task automatic t_lanes();
    req(1'b1, 17'h00000, 16'hAA77, 2'h1);
    req(1'b1, 17'h1FFFF, 16'hCD55, 2'h2);
    rd(17'h00000, 2'h0);
    chk("lower write", q, 16'h1277);
    rd(17'h1FFFF, 2'h0);
    chk("upper write", q, 16'hCDEF);
    rd(17'h00000, 2'h1);
    chk("lower read", q, 16'h0077);
    rd(17'h1FFFF, 2'h2);
    chk("upper read", q, 16'hCD00);
  endtask
  // timeout guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    chk("idle pins", {11'h000, cs_n, we_n, oe_n, up_n, lo_n}, 16'h001F);
    rst_b = 1'b1;
    t_word();
    t_lanes();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* tb/asc_mem_model.sv */
// asc_mem_model: behavioural 128K x 16 static memory seen at its pins
`timescale 1ns/1ps
`default_nettype none
module asc_mem_model
  import asc_pkg::*;
(
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic up_n,
  input wire logic lo_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] din,
  input wire logic [DATA_W-1:0] din_oe,
  output logic [DATA_W-1:0] line
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [1:0] drv;
  logic wr;
  // store only over the overlap of all selects
  assign wr = !cs_n && !we_n && !(up_n && lo_n);
  always @* begin
    if (wr && !lo_n) mem[addr][7:0] = din[7:0];
    if (wr && !up_n) mem[addr][15:8] = din[15:8];
  end
  // lanes drive only in a read with the gate low
  assign drv = (!cs_n && we_n && !oe_n) ? {!up_n, !lo_n} : 2'h0;
  // released lines show the inverse so stale data cannot pass
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      line[i] = din_oe[i] ? din[i] : (drv[i / BYTE_W] ? mem[addr][i] : ~mem[addr][i]);
    end
  end
endmodule
`default_nettype wire
